//--- core/prot_pkg.sv
package prot_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int CTRL_TICK_NS = 1000;
  localparam int TICK_CYCLES = (CTRL_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam longint SECOND_NS = 64'd1000000000;
  localparam int SECOND_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);
  // ****************************************
  // Settings and codes
  // ****************************************
  localparam int STALL_ACCEL_BIT = 0;
  localparam int STALL_CONST_BIT = 1;
  localparam int STALL_DECEL_BIT = 2;
  localparam logic [2:0] STALL_MASK_DEFAULT = 3'h3;
  localparam logic [7:0] STALL_LEVEL_MIN = 8'h1e;
  localparam logic [7:0] STALL_LEVEL_MAX = 8'h96;
  localparam logic [7:0] STALL_LEVEL_DEFAULT = 8'h96;
  localparam logic [7:0] PCT_FULL = 8'h64;
  localparam logic [15:0] DC_STALL_LEVEL = 16'h017c;
  localparam logic [4:0] OUT_SEL_IOL = 5'h06;
  localparam logic [4:0] OUT_SEL_STALL = 5'h07;
  localparam logic [4:0] OUT_SEL_LOSS = 5'h0b;
  localparam logic [4:0] OUT_SEL_FAULT = 5'h11;
  localparam logic [4:0] IN_SEL_EXT_NO = 5'h12;
  localparam logic [4:0] IN_SEL_EXT_NC = 5'h13;
  localparam logic [1:0] LOSS_CRIT_OFF = 2'h0;
  localparam logic [1:0] LOSS_CRIT_HALF = 2'h1;
  localparam logic [1:0] LOSS_CRIT_BELOW = 2'h2;
  localparam logic [1:0] LOSS_ACT_CONT = 2'h0;
  localparam logic [1:0] LOSS_ACT_FREE = 2'h1;
  localparam logic [1:0] LOSS_ACT_DECEL = 2'h2;
  localparam logic [6:0] LOSS_WAIT_MIN = 7'h01;
  localparam logic [6:0] LOSS_WAIT_MAX = 7'h78;
  localparam logic [6:0] LOSS_WAIT_DEFAULT = 7'h01;
  localparam logic [2:0] SRC_KEYPAD = 3'h0;
  localparam logic [2:0] SRC_VOLT = 3'h1;
  localparam logic [2:0] SRC_CUR = 3'h2;
  localparam logic [2:0] SRC_SUM = 3'h3;
  localparam logic [2:0] SRC_COMM = 3'h4;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    PHASE_STOP = 2'b00,
    PHASE_ACCEL = 2'b01,
    PHASE_CONST = 2'b10,
    PHASE_DECEL = 2'b11
  } ramp_phase_t;
  typedef enum logic [1:0] {
    LOSS_IDLE = 2'b00,
    LOSS_WAIT = 2'b01,
    LOSS_ACT = 2'b10
  } loss_state_t;
endpackage

//--- core/input_sync.sv
`timescale 1ns/1ns
module input_sync #(
  parameter int W = 5
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync_out;

  always_comb begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule

//--- core/loss_timer.sv
`timescale 1ns/1ns
module loss_timer #(
  parameter int SECOND_CYCLES = prot_pkg::SECOND_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [6:0] wait_secs,
  output logic expired
);
  localparam int PRE_W = $clog2(SECOND_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(SECOND_CYCLES - 1);
  logic [PRE_W-1:0] pre;
  logic [PRE_W-1:0] next_pre;
  logic [6:0] secs;
  logic [6:0] next_secs;
  logic next_expired;
  logic [6:0] limit;

  // ****************************************
  // Seconds count from onset of loss
  // ****************************************
  always_comb begin
    limit = wait_secs;
    if (limit < prot_pkg::LOSS_WAIT_MIN) begin
      limit = prot_pkg::LOSS_WAIT_MIN;
    end else if (limit > prot_pkg::LOSS_WAIT_MAX) begin
      limit = prot_pkg::LOSS_WAIT_MAX;
    end
    next_pre = pre;
    next_secs = secs;
    if (!run) begin
      next_pre = '0;
      next_secs = '0;
    end else if (!expired) begin
      if (pre == PRE_LAST) begin
        next_pre = '0;
        next_secs = secs + 7'h01;
      end else begin
        next_pre = pre + PRE_W'(1);
      end
    end
    next_expired = run && (next_secs >= limit);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre <= '0;
      secs <= '0;
      expired <= 1'b0;
    end else begin
      pre <= next_pre;
      secs <= next_secs;
      expired <= next_expired;
    end
  end
endmodule

//--- core/drive_protection_supervisor.sv
// Summary of operation
// - Accel stall enabled and current over level: hold frequency, stop accelerating.
// - Constant-speed stall enabled and current over level: lower output frequency.
// - Decel stall enabled and DC link above fixed level: pause deceleration.
// - Stall level is percent of motor rated current, range 30 to 150.
// - Mask bit 0 accel, bit 1 constant, bit 2 decel; default 3.
// - Output or relay selector code 7 shows stall prevention acting.
// - Held ramp simply lasts longer than the set ramp time.
// - Constant-speed reduction and recovery follow decel and accel rates.
// - Phase loss enable 1: any open output phase cuts the output.
// - Input selector code 18 is N.O. trip, 19 is N.C. trip.
// - N.O. trip input ON flags fault and cuts output.
// - N.C. trip input OFF flags fault and cuts output.
// - Current above inverter rated current activates overload prevention.
// - Selected output or relay alarms during inverter overload.
// - Loss criterion 0 disables; checked only for analog or comm sources.
// - Criterion 1: loss when input below half its minimum.
// - Criterion 2 with sum: loss when either input below its minimum.
// - After wait: action 0 continue, 1 free-run cut, 2 decel stop.
// - Wait time 1 to 120 seconds from onset of loss.
// - Output or relay selector code 11 shows command loss.
`timescale 1ns/1ns
module drive_protection_supervisor #(
  parameter int SECOND_CYCLES = prot_pkg::SECOND_CYCLES,
  parameter int TICK_CYCLES = prot_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] ramp_phase,
  input wire logic [15:0] output_current,
  input wire logic [15:0] motor_rated_current,
  input wire logic [15:0] inverter_rated_current,
  input wire logic [15:0] dc_link_voltage,
  input wire logic [2:0] phase_open,
  input wire logic [2:0] stall_enable_mask,
  input wire logic [7:0] stall_current_level,
  input wire logic [15:0] accel_time,
  input wire logic [15:0] decel_time_setting,
  input wire logic phase_loss_enable,
  input wire logic [4:0] digital_input,
  input wire logic [24:0] input_function,
  input wire logic [4:0] output_terminal_function,
  input wire logic [4:0] relay_function,
  input wire logic [2:0] freq_source,
  input wire logic [1:0] analog_loss_criteria,
  input wire logic [1:0] loss_drive_action,
  input wire logic [6:0] loss_wait_time,
  input wire logic [11:0] voltage_analog_input,
  input wire logic [11:0] voltage_input_min,
  input wire logic [11:0] current_analog_input,
  input wire logic [11:0] current_input_min,
  input wire logic comm_ref_valid,
  input wire logic fault_reset,
  output logic hold_accel,
  output logic reduce_freq,
  output logic hold_decel,
  output logic stall_active,
  output logic [15:0] stall_freq_offset,
  output logic phase_loss_fault,
  output logic ext_trip_fault,
  output logic inverter_overload,
  output logic freq_cmd_lost,
  output logic hold_last_freq,
  output logic loss_decel_stop,
  output logic output_cut,
  output logic open_collector_output,
  output logic fault_relay_contact
);
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  // True when meas exceeds pct percent of base
  function automatic logic pct_over(input logic [15:0] meas, input logic [15:0] base,
                                    input logic [7:0] pct);
    logic [23:0] lhs;
    logic [23:0] rhs;
    lhs = 24'(meas) * 24'(prot_pkg::PCT_FULL);
    rhs = 24'(base) * 24'(pct);
    return lhs > rhs;
  endfunction

  // Below minimum, or below half of it
  function automatic logic below_min(input logic [11:0] level, input logic [11:0] min,
                                     input logic half);
    if (half) begin
      return {level, 1'b0} < {1'b0, min};
    end
    return level < min;
  endfunction

  // Status carried by a multi-function output selector
  function automatic logic out_select(input logic [4:0] code, input logic iol,
                                      input logic stall, input logic lost,
                                      input logic trip);
    case (code)
      prot_pkg::OUT_SEL_IOL: return iol;
      prot_pkg::OUT_SEL_STALL: return stall;
      prot_pkg::OUT_SEL_LOSS: return lost;
      prot_pkg::OUT_SEL_FAULT: return trip;
      default: return 1'b0;
    endcase
  endfunction

  // ****************************************
  // Control tick and samples
  // ****************************************
  logic [TICK_W-1:0] tick_cnt;
  logic [TICK_W-1:0] next_tick_cnt;
  logic tick;
  logic [15:0] s_current;
  logic [15:0] s_dc;
  logic [2:0] s_open;
  logic [11:0] s_volt;
  logic [11:0] s_cur_in;
  logic s_comm;
  logic [15:0] next_s_current;
  logic [15:0] next_s_dc;
  logic [2:0] next_s_open;
  logic [11:0] next_s_volt;
  logic [11:0] next_s_cur_in;
  logic next_s_comm;
  logic [4:0] din;

  input_sync #(.W(5)) u_din_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(digital_input),
    .sync_out(din)
  );

  assign tick = (tick_cnt == TICK_LAST);

  always_comb begin
    next_tick_cnt = tick ? '0 : tick_cnt + TICK_W'(1);
    next_s_current = s_current;
    next_s_dc = s_dc;
    next_s_open = s_open;
    next_s_volt = s_volt;
    next_s_cur_in = s_cur_in;
    next_s_comm = s_comm;
    if (tick) begin
      next_s_current = output_current;
      next_s_dc = dc_link_voltage;
      next_s_open = phase_open;
      next_s_volt = voltage_analog_input;
      next_s_cur_in = current_analog_input;
      next_s_comm = comm_ref_valid;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tick_cnt <= '0;
      s_current <= '0;
      s_dc <= '0;
      s_open <= '0;
      s_volt <= '0;
      s_cur_in <= '0;
      s_comm <= 1'b1;
    end else begin
      tick_cnt <= next_tick_cnt;
      s_current <= next_s_current;
      s_dc <= next_s_dc;
      s_open <= next_s_open;
      s_volt <= next_s_volt;
      s_cur_in <= next_s_cur_in;
      s_comm <= next_s_comm;
    end
  end

  // ****************************************
  // Comparisons
  // ****************************************
  logic [7:0] level;
  logic over_stall;
  logic over_dc;
  logic over_inv;
  logic ext_now;
  logic loss_now;
  logic half;

  always_comb begin
    level = stall_current_level;
    if (level < prot_pkg::STALL_LEVEL_MIN) begin
      level = prot_pkg::STALL_LEVEL_MIN;
    end else if (level > prot_pkg::STALL_LEVEL_MAX) begin
      level = prot_pkg::STALL_LEVEL_MAX;
    end
    over_stall = pct_over(s_current, motor_rated_current, level);
    over_dc = s_dc > prot_pkg::DC_STALL_LEVEL;
    over_inv = pct_over(s_current, inverter_rated_current, prot_pkg::PCT_FULL);
    ext_now = 1'b0;
    for (int k = 0; k < 5; k++) begin
      if (input_function[k*5 +: 5] == prot_pkg::IN_SEL_EXT_NO && din[k]) begin
        ext_now = 1'b1;
      end
      if (input_function[k*5 +: 5] == prot_pkg::IN_SEL_EXT_NC && !din[k]) begin
        ext_now = 1'b1;
      end
    end
    half = (analog_loss_criteria == prot_pkg::LOSS_CRIT_HALF);
    loss_now = 1'b0;
    if (analog_loss_criteria == prot_pkg::LOSS_CRIT_HALF ||
        analog_loss_criteria == prot_pkg::LOSS_CRIT_BELOW) begin
      case (freq_source)
        prot_pkg::SRC_VOLT: loss_now = below_min(s_volt, voltage_input_min, half);
        prot_pkg::SRC_CUR: loss_now = below_min(s_cur_in, current_input_min, half);
        prot_pkg::SRC_SUM: loss_now = below_min(s_volt, voltage_input_min, half) ||
                                      below_min(s_cur_in, current_input_min, half);
        prot_pkg::SRC_COMM: loss_now = !s_comm;
        default: loss_now = 1'b0;
      endcase
    end
  end

  // ****************************************
  // Stall prevention
  // ****************************************
  logic [15:0] step_cnt;
  logic [15:0] next_step_cnt;
  logic next_hold_accel;
  logic next_reduce_freq;
  logic next_hold_decel;
  logic [15:0] next_offset;

  always_comb begin
    next_hold_accel = stall_enable_mask[prot_pkg::STALL_ACCEL_BIT] &&
                      ramp_phase == prot_pkg::PHASE_ACCEL && over_stall;
    next_reduce_freq = stall_enable_mask[prot_pkg::STALL_CONST_BIT] &&
                       ramp_phase == prot_pkg::PHASE_CONST && over_stall;
    next_hold_decel = stall_enable_mask[prot_pkg::STALL_DECEL_BIT] &&
                      ramp_phase == prot_pkg::PHASE_DECEL && over_dc;
    next_step_cnt = step_cnt;
    next_offset = stall_freq_offset;
    if (tick) begin
      if (reduce_freq) begin
        if (step_cnt >= decel_time_setting) begin
          next_step_cnt = '0;
          next_offset = (stall_freq_offset == 16'hffff) ? stall_freq_offset
                                                        : stall_freq_offset + 16'h0001;
        end else begin
          next_step_cnt = step_cnt + 16'h0001;
        end
      end else if (stall_freq_offset != 16'h0000) begin
        if (step_cnt >= accel_time) begin
          next_step_cnt = '0;
          next_offset = stall_freq_offset - 16'h0001;
        end else begin
          next_step_cnt = step_cnt + 16'h0001;
        end
      end else begin
        next_step_cnt = '0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold_accel <= 1'b0;
      reduce_freq <= 1'b0;
      hold_decel <= 1'b0;
      step_cnt <= '0;
      stall_freq_offset <= '0;
    end else begin
      hold_accel <= next_hold_accel;
      reduce_freq <= next_reduce_freq;
      hold_decel <= next_hold_decel;
      step_cnt <= next_step_cnt;
      stall_freq_offset <= next_offset;
    end
  end

  assign stall_active = hold_accel || reduce_freq || hold_decel;

  // ****************************************
  // Trips and command loss
  // ****************************************
  prot_pkg::loss_state_t loss_state;
  prot_pkg::loss_state_t next_loss_state;
  logic loss_expired;
  logic next_phase_loss_fault;
  logic next_ext_trip_fault;
  logic next_inverter_overload;
  logic next_oc_out;
  logic next_relay_out;
  logic any_trip;

  loss_timer #(.SECOND_CYCLES(SECOND_CYCLES)) u_loss_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(loss_now),
    .wait_secs(loss_wait_time),
    .expired(loss_expired)
  );

  assign any_trip = phase_loss_fault || ext_trip_fault || inverter_overload;

  always_comb begin
    // Set wins over reset
    // Phase loss trip
    next_phase_loss_fault = (phase_loss_enable && (|s_open)) ||
                            (phase_loss_fault && !fault_reset);
    next_ext_trip_fault = ext_now || (ext_trip_fault && !fault_reset);
    next_inverter_overload = over_inv;
    next_loss_state = loss_state;
    case (loss_state)
      prot_pkg::LOSS_IDLE: if (loss_now) next_loss_state = prot_pkg::LOSS_WAIT;
      prot_pkg::LOSS_WAIT: begin
        if (!loss_now) begin
          next_loss_state = prot_pkg::LOSS_IDLE;
        end else if (loss_expired) begin
          next_loss_state = prot_pkg::LOSS_ACT;
        end
      end
      prot_pkg::LOSS_ACT: if (!loss_now) next_loss_state = prot_pkg::LOSS_IDLE;
      default: next_loss_state = prot_pkg::LOSS_IDLE;
    endcase
    next_oc_out = out_select(output_terminal_function, inverter_overload, stall_active,
                             freq_cmd_lost, any_trip);
    next_relay_out = out_select(relay_function, inverter_overload, stall_active,
                                freq_cmd_lost, any_trip);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_loss_fault <= 1'b0;
      ext_trip_fault <= 1'b0;
      inverter_overload <= 1'b0;
      loss_state <= prot_pkg::LOSS_IDLE;
      open_collector_output <= 1'b0;
      fault_relay_contact <= 1'b0;
    end else begin
      phase_loss_fault <= next_phase_loss_fault;
      ext_trip_fault <= next_ext_trip_fault;
      inverter_overload <= next_inverter_overload;
      loss_state <= next_loss_state;
      open_collector_output <= next_oc_out;
      fault_relay_contact <= next_relay_out;
    end
  end

  assign freq_cmd_lost = (loss_state == prot_pkg::LOSS_ACT);
  assign hold_last_freq = freq_cmd_lost && loss_drive_action == prot_pkg::LOSS_ACT_CONT;
  assign loss_decel_stop = freq_cmd_lost && loss_drive_action == prot_pkg::LOSS_ACT_DECEL;
  assign output_cut = phase_loss_fault || ext_trip_fault ||
                      (freq_cmd_lost && loss_drive_action == prot_pkg::LOSS_ACT_FREE);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  accel_hold_a: assert property (
    (ramp_phase == prot_pkg::PHASE_ACCEL && stall_enable_mask[0] && over_stall)
    |=> hold_accel && stall_active) else $error("accel stall not held");
  const_reduce_a: assert property (
    (ramp_phase == prot_pkg::PHASE_CONST && stall_enable_mask[1] && over_stall)
    |=> reduce_freq) else $error("constant stall not reducing");
  decel_pause_a: assert property (
    (ramp_phase == prot_pkg::PHASE_DECEL && !stall_enable_mask[2])
    |=> !hold_decel) else $error("decel hold while disabled");
  stall_output_a: assert property (
    (output_terminal_function == prot_pkg::OUT_SEL_STALL && stall_active)
    |=> open_collector_output) else $error("stall output missing");
  phase_cut_a: assert property (
    (phase_loss_enable && |s_open) |=> phase_loss_fault && output_cut)
    else $error("phase loss not cut");
  ext_trip_a: assert property (
    ext_now |=> ext_trip_fault ##0 output_cut) else $error("external trip missed");
  inv_over_a: assert property (
    over_inv |=> inverter_overload) else $error("overload not flagged");
  loss_restart_a: assert property (
    !loss_now |=> !freq_cmd_lost) else $error("loss held after recovery");
  loss_free_a: assert property (
    (freq_cmd_lost && loss_drive_action == prot_pkg::LOSS_ACT_FREE) |-> output_cut)
    else $error("free run not cut");
  offset_pace_a: assert property (
    $changed(stall_freq_offset) |-> $past(tick)) else $error("offset moved off tick");

  accel_hold_c: cover property (hold_accel);
  loss_act_c: cover property (loss_state == prot_pkg::LOSS_WAIT ##1 freq_cmd_lost);
  ext_trip_c: cover property ($rose(ext_trip_fault));
endmodule

//--- tb/power_stage_model.sv
`timescale 1ns/1ns
// ****************************************
// Power stage: current flows only while output is on
// ****************************************
module power_stage_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [15:0] load_current,
  input wire logic output_cut,
  output logic [15:0] output_current
);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      output_current <= 16'h0;
    end else begin
      output_current <= output_cut ? 16'h0 : load_current;
    end
  end
endmodule

//--- tb/test_drive_protection_supervisor.sv
`timescale 1ns/1ns
module test_drive_protection_supervisor;
  logic ref_clk = 0, rst = 1, phase_loss_enable = 0, comm_ref_valid = 1, fault_reset = 0;
  logic [1:0] ramp_phase = 0, analog_loss_criteria = 0, loss_drive_action = 0;
  logic [15:0] output_current, load = 0, motor_rated_current = 16'h3e8;
  logic [15:0] inverter_rated_current = 16'h7d0, dc_link_voltage = 16'h0, accel_time = 16'h2;
  logic [15:0] decel_time_setting = 16'h2;
  logic [2:0] phase_open = 0, stall_enable_mask = 0, freq_source = 0;
  logic [7:0] stall_current_level = 8'h64;
  logic [4:0] digital_input = 0, output_terminal_function = 0, relay_function = 0;
  logic [24:0] input_function = 0;
  logic [6:0] loss_wait_time = 7'h01;
  logic [11:0] voltage_analog_input = 0, voltage_input_min = 0;
  logic [11:0] current_analog_input = 0, current_input_min = 0;
  logic hold_accel, reduce_freq, hold_decel, stall_active, phase_loss_fault, ext_trip_fault;
  logic inverter_overload, freq_cmd_lost, hold_last_freq, loss_decel_stop, output_cut;
  logic open_collector_output, fault_relay_contact;
  logic [15:0] stall_freq_offset;
  int err_total = 0, total_checks = 0;
  always #20 ref_clk = ~ref_clk;
  power_stage_model u_power_stage_model (.ref_clk, .rst, .load_current(load), .output_cut,
    .output_current);
  drive_protection_supervisor #(.SECOND_CYCLES(50), .TICK_CYCLES(4))
    u_drive_protection_supervisor (.ref_clk, .rst, .ramp_phase, .output_current,
    .motor_rated_current, .inverter_rated_current, .dc_link_voltage, .phase_open,
    .stall_enable_mask, .stall_current_level, .accel_time, .decel_time_setting,
    .phase_loss_enable, .digital_input, .input_function, .output_terminal_function,
    .relay_function, .freq_source, .analog_loss_criteria, .loss_drive_action, .loss_wait_time,
    .voltage_analog_input, .voltage_input_min, .current_analog_input, .current_input_min,
    .comm_ref_valid, .fault_reset, .hold_accel, .reduce_freq, .hold_decel, .stall_active,
    .stall_freq_offset, .phase_loss_fault, .ext_trip_fault, .inverter_overload,
    .freq_cmd_lost, .hold_last_freq, .loss_decel_stop, .output_cut, .open_collector_output,
    .fault_relay_contact);
  // ****************************************
  // Helpers
  // ****************************************
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task clear_faults;
    fault_reset = 1;
    cyc(4);
    fault_reset = 0;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_stall;
    ramp_phase = 2'b01;
    stall_enable_mask = 3'h1;
    output_terminal_function = prot_pkg::OUT_SEL_STALL;
    load = 16'd1200;
    cyc(10);
    chk(hold_accel, 1);
    chk(open_collector_output, 1);
    stall_enable_mask = 3'h6;
    cyc(10);
    chk(stall_active, 0);
    stall_current_level = 8'h96;
    stall_enable_mask = 3'h1;
    load = 16'd1500;
    cyc(10);
    chk(hold_accel, 0);
    load = 16'd1501;
    cyc(10);
    chk(hold_accel, 1);
    ramp_phase = 2'b10;
    stall_enable_mask = 3'h2;
    cyc(10);
    chk(reduce_freq, 1);
    cyc(30);
    chk(stall_freq_offset != 16'h0, 1);
    load = 16'd900;
    ramp_phase = 2'b11;
    stall_enable_mask = 3'h4;
    dc_link_voltage = 16'd400;
    cyc(10);
    chk({reduce_freq, hold_decel}, 2'b01);
    dc_link_voltage = 16'd370;
    cyc(10);
    chk(stall_active, 0);
    stall_enable_mask = 3'h0;
    cyc(40);
    chk(stall_freq_offset, 16'h0);
  endtask
  task t_trips;
    phase_open = 3'h2;
    cyc(10);
    chk(phase_loss_fault, 0);
    phase_loss_enable = 1;
    cyc(10);
    chk({phase_loss_fault, output_cut}, 2'b11);
    phase_open = 3'h0;
    digital_input = 5'h10;
    cyc(6);
    clear_faults();
    relay_function = prot_pkg::OUT_SEL_FAULT;
    input_function = {prot_pkg::IN_SEL_EXT_NC, prot_pkg::IN_SEL_EXT_NO, 15'h0};
    cyc(6);
    chk({phase_loss_fault, ext_trip_fault}, 2'b00);
    digital_input = 5'h18;
    cyc(6);
    chk({ext_trip_fault, output_cut, fault_relay_contact}, 3'h7);
    digital_input = 5'h10;
    clear_faults();
    cyc(3);
    chk(ext_trip_fault, 0);
    digital_input = 5'h00;
    cyc(6);
    chk({ext_trip_fault, output_cut}, 2'b11);
    digital_input = 5'h10;
    clear_faults();
  endtask
  task t_overload;
    output_terminal_function = prot_pkg::OUT_SEL_IOL;
    load = 16'd2001;
    cyc(10);
    chk({inverter_overload, open_collector_output}, 2'b11);
    load = 16'd2000;
    cyc(10);
    chk(inverter_overload, 0);
    load = 16'd500;
  endtask
  task t_loss;
    freq_source = prot_pkg::SRC_VOLT;
    voltage_input_min = 12'd1000;
    voltage_analog_input = 12'd0;
    relay_function = prot_pkg::OUT_SEL_LOSS;
    cyc(80);
    chk(freq_cmd_lost, 0);
    analog_loss_criteria = prot_pkg::LOSS_CRIT_HALF;
    for (int act = 0; act < 3; act++) begin
      loss_drive_action = act[1:0];
      voltage_analog_input = 12'd499;
      cyc(20);
      chk(freq_cmd_lost, 0);
      voltage_analog_input = 12'd500;
      cyc(6);
      voltage_analog_input = 12'd499;
      cyc(40);
      chk(freq_cmd_lost, 0);
      cyc(30);
      chk({freq_cmd_lost, fault_relay_contact}, 2'b11);
      chk({hold_last_freq, output_cut, loss_decel_stop}, 3'h4 >> act);
      voltage_analog_input = 12'd600;
      cyc(10);
      chk(freq_cmd_lost, 0);
    end
    freq_source = prot_pkg::SRC_SUM;
    analog_loss_criteria = prot_pkg::LOSS_CRIT_BELOW;
    current_input_min = 12'd100;
    current_analog_input = 12'd99;
    voltage_analog_input = 12'd1000;
    cyc(80);
    chk(freq_cmd_lost, 1);
    freq_source = prot_pkg::SRC_COMM;
    cyc(10);
    chk(freq_cmd_lost, 0);
    comm_ref_valid = 0;
    cyc(80);
    chk(freq_cmd_lost, 1);
  endtask
  initial begin
    repeat (16) @(negedge ref_clk);
    rst = 0;
    cyc(30);
    t_stall();
    t_trips();
    t_overload();
    t_loss();
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    give_verdict();
  end
endmodule
